// ### src/palc_pkg.sv
// power average limit checker: constants, register map, types and the behaviour list
// What this block does
// - averaging filter combines 1 to 1024 successive readings into one result
// - averaging control bit; cleared bypasses the filter, set uses it
// - automatic mode picks filter length from resolution and present power level
// - writing a filter length turns automatic length selection off
// - reading rates let a 1024 filter settle in about 50.5, 25.3, 2.10 s
// - writing the channel offset value sets the offset-enable state
// - offset-enable is writable alone; clearing it keeps the stored offset
// - offset is signed; negative is loss, positive is gain
// - log-unit limits accepted from -150.00 to +230.00 dBm inclusive
// - log-unit limits reset to +90.00 dBm upper and -90.00 dBm lower
// - watt-unit limits span 1e-18 to 1e20 W, defaults 1e6 and 1e-12 W
// - with checking on, results strictly outside the limits are recorded failures
// - failure flag query reads 1 after any failure since last clear, else 0
// - failure flag is sticky until the failure record is cleared
// - failure counter steps once per failing measurement, holds at 65535, and is readable
// - auto-clear switch; off keeps counter and flag until explicit clear
// - explicit clear zeroes the counter and drops the flag; a failure in the same cycle leaves count 1 and the flag set
// - in settled mode only filter-completed measurements are checked
// - settled mode completes only after the filter is full of fresh readings
package palc_pkg;
  localparam int DATA_W  = 32;
  localparam int ADDR_W  = 8;
  localparam int MAX_LEN = 1024;
  localparam int LEN_W   = 11;
  localparam int PTR_W   = 10;
  localparam int CNT_W   = 16;
  localparam int SUM_W   = 42;
  localparam int DIV_W   = 24;
  localparam int CLK_MHZ = 25;
  // reading periods chosen so that 1024 readings span the settling figures
  localparam int NORMAL_SETTLE_MS_X10 = 505;
  localparam int DOUBLE_SETTLE_MS_X10 = 253;
  localparam int FAST_SETTLE_MS_X10   = 21;
  localparam int NORMAL_CYCLES = (NORMAL_SETTLE_MS_X10 * 100 * 1000 * CLK_MHZ) / MAX_LEN;
  localparam int DOUBLE_CYCLES = (DOUBLE_SETTLE_MS_X10 * 100 * 1000 * CLK_MHZ) / MAX_LEN;
  localparam int FAST_CYCLES   = (FAST_SETTLE_MS_X10 * 100 * 1000 * CLK_MHZ) / MAX_LEN;
  localparam logic [ADDR_W-1:0] REG_CTRL       = 8'h00;
  localparam logic [ADDR_W-1:0] REG_FILTER_LEN = 8'h04;
  localparam logic [ADDR_W-1:0] REG_OFFSET     = 8'h08;
  localparam logic [ADDR_W-1:0] REG_OFFSET_ON  = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_UPPER      = 8'h10;
  localparam logic [ADDR_W-1:0] REG_LOWER      = 8'h14;
  localparam logic [ADDR_W-1:0] REG_FAIL_FLAG  = 8'h18;
  localparam logic [ADDR_W-1:0] REG_FAIL_COUNT = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_FAIL_CLEAR = 8'h20;
  localparam logic [ADDR_W-1:0] REG_INIT       = 8'h24;
  localparam logic [ADDR_W-1:0] REG_RESULT     = 8'h28;
  localparam logic [ADDR_W-1:0] REG_STATUS     = 8'h2C;
  // values in hundredths of a dB: dBm, or dB relative to 1 W in watt unit
  localparam logic signed [DATA_W-1:0] LOG_MAX     = 32'h000059D8;
  localparam logic signed [DATA_W-1:0] LOG_MIN     = 32'hFFFFC568;
  localparam logic signed [DATA_W-1:0] LOG_DEF_UP  = 32'h00002328;
  localparam logic signed [DATA_W-1:0] LOG_DEF_LO  = 32'hFFFFDCD8;
  localparam logic signed [DATA_W-1:0] LIN_MAX     = 32'h00004E20;
  localparam logic signed [DATA_W-1:0] LIN_MIN     = 32'hFFFFB9B0;
  localparam logic signed [DATA_W-1:0] LIN_DEF_UP  = 32'h00001770;
  localparam logic signed [DATA_W-1:0] LIN_DEF_LO  = 32'hFFFFD120;
  localparam logic signed [DATA_W-1:0] DBM_TO_DBW  = 32'h00000BB8;
  localparam logic signed [DATA_W-1:0] POWER_HIGH  = 32'h000003E8;
  localparam logic signed [DATA_W-1:0] POWER_LOW   = 32'hFFFFF830;
  localparam logic [LEN_W-1:0] LEN_ONE = 11'h001;
  localparam logic [LEN_W-1:0] LEN_MAX = 11'h400;
  localparam logic [3:0] BAND_SHIFT_HIGH = 4'h0;
  localparam logic [3:0] BAND_SHIFT_MID  = 4'h2;
  localparam logic [3:0] BAND_SHIFT_LOW  = 4'h4;
  localparam logic [1:0] RATE_NORMAL = 2'h0;
  localparam logic [1:0] RATE_DOUBLE = 2'h1;
  localparam logic [1:0] RATE_FAST   = 2'h2;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;

  typedef struct packed {
    logic       continuous;
    logic [1:0] resolution;
    logic [1:0] rate;
    logic       unitLin;
    logic       autoClear;
    logic       limitOn;
    logic       settled;
    logic       autoLen;
    logic       avgOn;
  } palc_ctrl_t;

  localparam palc_ctrl_t CTRL_RESET = 11'h003;
  localparam int CTRL_W = 11;

  typedef enum logic [0:0] {
    MS_IDLE = 1'b0,
    MS_RUN  = 1'b1
  } palc_meas_t;
endpackage

// ### src/palc_core.sv
// power average limit checker: filter, offset, limit check and register port
`timescale 1ns/100ps
`default_nettype none
module palc_core #(
  parameter int NORMAL_CYCLES = palc_pkg::NORMAL_CYCLES,
  parameter int DOUBLE_CYCLES = palc_pkg::DOUBLE_CYCLES,
  parameter int FAST_CYCLES   = palc_pkg::FAST_CYCLES,
  parameter int MAX_LEN       = palc_pkg::MAX_LEN
) (
  input  wire logic                                   clk,
  input  wire logic                                   arst_n,
  input  wire logic signed [palc_pkg::DATA_W-1:0]     sampleIn,
  input  wire logic        [palc_pkg::ADDR_W-1:0]     busAddr,
  input  wire logic        [palc_pkg::DATA_W-1:0]     busWrData,
  input  wire logic                                   busWr,
  input  wire logic                                   busRd,
  output var  logic        [palc_pkg::DATA_W-1:0]     busRdData,
  output var  logic signed [palc_pkg::DATA_W-1:0]     measResult,
  output var  logic                                   measDone,
  output var  logic                                   limitFail
);
  localparam int DW = palc_pkg::DATA_W;
  localparam int LW = palc_pkg::LEN_W;
  localparam int PW = palc_pkg::PTR_W;
  localparam int SW = palc_pkg::SUM_W;
  localparam int VW = palc_pkg::DIV_W;
  localparam int CW = palc_pkg::CNT_W;

  // bus decode
  logic wrCtrl, wrLen, wrOff, wrOffOn, wrUp, wrLo, wrClear, wrInit;
  assign wrCtrl  = busWr && (busAddr == palc_pkg::REG_CTRL);
  assign wrLen   = busWr && (busAddr == palc_pkg::REG_FILTER_LEN);
  assign wrOff   = busWr && (busAddr == palc_pkg::REG_OFFSET);
  assign wrOffOn = busWr && (busAddr == palc_pkg::REG_OFFSET_ON);
  assign wrUp    = busWr && (busAddr == palc_pkg::REG_UPPER);
  assign wrLo    = busWr && (busAddr == palc_pkg::REG_LOWER);
  assign wrClear = busWr && (busAddr == palc_pkg::REG_FAIL_CLEAR);
  assign wrInit  = busWr && (busAddr == palc_pkg::REG_INIT);

  // configuration state
  palc_pkg::palc_ctrl_t ctrl, next_ctrl;
  logic        [LW-1:0] lenReg, next_lenReg;
  logic signed [DW-1:0] offsetVal, next_offsetVal;
  logic                 offsetOn, next_offsetOn;
  logic signed [DW-1:0] upperLim, next_upperLim;
  logic signed [DW-1:0] lowerLim, next_lowerLim;
  palc_pkg::palc_ctrl_t wrCtrlVal;
  logic signed [DW-1:0] wrSigned;
  logic signed [DW-1:0] rangeMax, rangeMin;

  assign wrCtrlVal = palc_pkg::palc_ctrl_t'(busWrData[palc_pkg::CTRL_W-1:0]);
  assign wrSigned  = $signed(busWrData);
  assign rangeMax  = ctrl.unitLin ? palc_pkg::LIN_MAX : palc_pkg::LOG_MAX;
  assign rangeMin  = ctrl.unitLin ? palc_pkg::LIN_MIN : palc_pkg::LOG_MIN;

  always_comb begin
    next_ctrl      = ctrl;
    next_lenReg    = lenReg;
    next_offsetVal = offsetVal;
    next_offsetOn  = offsetOn;
    next_upperLim  = upperLim;
    next_lowerLim  = lowerLim;
    if (wrCtrl) begin
      next_ctrl = wrCtrlVal;
      // a unit change reloads that unit's default limits
      if (wrCtrlVal.unitLin != ctrl.unitLin) begin
        next_upperLim = wrCtrlVal.unitLin ? palc_pkg::LIN_DEF_UP : palc_pkg::LOG_DEF_UP;
        next_lowerLim = wrCtrlVal.unitLin ? palc_pkg::LIN_DEF_LO : palc_pkg::LOG_DEF_LO;
      end
    end
    if (wrLen) begin
      if (busWrData == '0) begin
        next_lenReg = palc_pkg::LEN_ONE;
      end else if (busWrData > DW'(palc_pkg::LEN_MAX)) begin
        next_lenReg = palc_pkg::LEN_MAX;
      end else begin
        next_lenReg = busWrData[LW-1:0];
      end
      next_ctrl.autoLen = 1'b0;
    end
    if (wrOff) begin
      next_offsetVal = wrSigned;
      next_offsetOn  = 1'b1;
    end
    if (wrOffOn) begin
      next_offsetOn = busWrData[0];
    end
    // out-of-range limits are clamped rather than refused
    if (wrUp) begin
      next_upperLim = (wrSigned > rangeMax) ? rangeMax : (wrSigned < rangeMin) ? rangeMin : wrSigned;
    end
    if (wrLo) begin
      next_lowerLim = (wrSigned > rangeMax) ? rangeMax : (wrSigned < rangeMin) ? rangeMin : wrSigned;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl      <= palc_pkg::CTRL_RESET;
      lenReg    <= palc_pkg::LEN_ONE;
      offsetVal <= '0;
      offsetOn  <= 1'b0;
      upperLim  <= palc_pkg::LOG_DEF_UP;
      lowerLim  <= palc_pkg::LOG_DEF_LO;
    end else begin
      ctrl      <= next_ctrl;
      lenReg    <= next_lenReg;
      offsetVal <= next_offsetVal;
      offsetOn  <= next_offsetOn;
      upperLim  <= next_upperLim;
      lowerLim  <= next_lowerLim;
    end
  end

  // reading-rate divider
  logic [VW-1:0] divCnt, next_divCnt, divTop;
  logic          tick, next_tick;
  always_comb begin
    case (ctrl.rate)
      palc_pkg::RATE_DOUBLE: divTop = VW'(DOUBLE_CYCLES - 1);
      palc_pkg::RATE_FAST:   divTop = VW'(FAST_CYCLES - 1);
      default:               divTop = VW'(NORMAL_CYCLES - 1);
    endcase
    next_tick   = 1'b0;
    next_divCnt = divCnt + 1'b1;
    if (divCnt >= divTop) begin
      next_divCnt = '0;
      next_tick   = 1'b1;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      divCnt <= '0;
      tick   <= 1'b0;
    end else begin
      divCnt <= next_divCnt;
      tick   <= next_tick;
    end
  end

  // filter length selection
  logic signed [DW-1:0] powerLevel;
  logic        [3:0]    bandShift, autoShift;
  logic        [LW-1:0] autoLenVal, effLen;
  always_comb begin
    if (powerLevel >= palc_pkg::POWER_HIGH) begin
      bandShift = palc_pkg::BAND_SHIFT_HIGH;
    end else if (powerLevel >= palc_pkg::POWER_LOW) begin
      bandShift = palc_pkg::BAND_SHIFT_MID;
    end else begin
      bandShift = palc_pkg::BAND_SHIFT_LOW;
    end
    // finer resolution and weaker signal both ask for more readings
    autoShift  = {1'b0, ctrl.resolution, 1'b0} + bandShift;
    autoLenVal = palc_pkg::LEN_ONE << autoShift;
    if (!ctrl.avgOn) begin
      effLen = palc_pkg::LEN_ONE;
    end else if (ctrl.autoLen) begin
      effLen = autoLenVal;
    end else begin
      effLen = lenReg;
    end
  end

  // moving-sum filter
  logic signed [DW-1:0] sampleBuf [MAX_LEN];
  logic        [PW-1:0] wrPtr, next_wrPtr, oldIdx;
  logic        [LW-1:0] fill, next_fill, lastLen, next_lastLen;
  logic signed [SW-1:0] sum, next_sum;
  logic signed [DW-1:0] lastSample, next_lastSample;
  logic                 pend, next_pend;
  logic                 filtRestart;
  palc_pkg::palc_meas_t mstate, next_mstate;

  assign oldIdx      = wrPtr - effLen[PW-1:0];
  // settled initiation demands fresh readings only
  assign filtRestart = (effLen != lastLen) || (wrInit && ctrl.settled);

  always_comb begin
    next_wrPtr      = wrPtr;
    next_fill       = fill;
    next_sum        = sum;
    next_lastLen    = effLen;
    next_lastSample = lastSample;
    next_pend       = tick;
    if (filtRestart) begin
      next_fill = '0;
      next_sum  = '0;
    end
    if (tick) begin
      next_wrPtr      = wrPtr + 1'b1;
      next_lastSample = sampleIn;
      if (filtRestart) begin
        next_fill = palc_pkg::LEN_ONE;
        next_sum  = SW'(sampleIn);
      end else if (fill < effLen) begin
        next_fill = fill + 1'b1;
        next_sum  = sum + SW'(sampleIn);
      end else begin
        next_sum = sum + SW'(sampleIn) - SW'(sampleBuf[oldIdx]);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr      <= '0;
      fill       <= '0;
      sum        <= '0;
      lastLen    <= palc_pkg::LEN_ONE;
      lastSample <= '0;
      pend       <= 1'b0;
    end else begin
      wrPtr      <= next_wrPtr;
      fill       <= next_fill;
      sum        <= next_sum;
      lastLen    <= next_lastLen;
      lastSample <= next_lastSample;
      pend       <= next_pend;
    end
  end

  // storage written without reset; only slots inside the fill count are ever read
  always_ff @(posedge clk) begin
    if (tick) begin
      sampleBuf[wrPtr] <= sampleIn;
    end
  end

  // result path: average, offset, unit, check
  logic signed [SW-1:0] quot;
  logic signed [DW-1:0] avgVal, corrVal, unitVal;
  logic                 complete, failNow;
  assign quot     = sum / $signed({{(SW-LW){1'b0}}, effLen});
  assign avgVal   = ctrl.avgOn ? quot[DW-1:0] : lastSample;
  assign corrVal  = avgVal + (offsetOn ? offsetVal : '0);
  assign unitVal  = ctrl.unitLin ? corrVal - palc_pkg::DBM_TO_DBW : corrVal;
  assign complete = pend && (mstate == palc_pkg::MS_RUN) && (!ctrl.settled || fill == effLen);
  assign failNow  = complete && ctrl.limitOn && ((unitVal < lowerLim) || (unitVal > upperLim));

  logic [CW-1:0]        failCount, next_failCount;
  logic                 failFlag, next_failFlag;
  logic signed [DW-1:0] next_measResult, next_powerLevel;
  logic                 next_measDone;
  logic [DW-1:0]        next_busRdData;
  logic                 clearNow;
  assign clearNow = wrClear || (wrInit && ctrl.autoClear);

  always_comb begin
    next_mstate     = mstate;
    next_failCount  = failCount;
    next_failFlag   = failFlag;
    next_measResult = measResult;
    next_measDone   = complete;
    next_powerLevel = pend ? avgVal : powerLevel;
    if (complete) begin
      next_measResult = unitVal;
      if (!ctrl.continuous) begin
        next_mstate = palc_pkg::MS_IDLE;
      end
    end
    if (wrInit) begin
      next_mstate = palc_pkg::MS_RUN;
    end
    // without a clear the record only grows
    if (clearNow) begin
      next_failCount = '0;
      next_failFlag  = 1'b0;
    end
    // a failure landing on a clear survives it
    if (failNow) begin
      next_failFlag = 1'b1;
      if (clearNow) begin
        next_failCount = {{(CW-1){1'b0}}, 1'b1};
      end else if (failCount != palc_pkg::CNT_MAX) begin
        next_failCount = failCount + 1'b1;
      end
    end
    next_busRdData = '0;
    if (busRd) begin
      case (busAddr)
        palc_pkg::REG_CTRL:       next_busRdData = DW'(ctrl);
        palc_pkg::REG_FILTER_LEN: next_busRdData = DW'(effLen);
        palc_pkg::REG_OFFSET:     next_busRdData = offsetVal;
        palc_pkg::REG_OFFSET_ON:  next_busRdData = DW'(offsetOn);
        palc_pkg::REG_UPPER:      next_busRdData = upperLim;
        palc_pkg::REG_LOWER:      next_busRdData = lowerLim;
        palc_pkg::REG_FAIL_FLAG:  next_busRdData = DW'(failFlag);
        palc_pkg::REG_FAIL_COUNT: next_busRdData = DW'(failCount);
        palc_pkg::REG_RESULT:     next_busRdData = measResult;
        palc_pkg::REG_STATUS:     next_busRdData = DW'({mstate, fill});
        default:                  next_busRdData = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mstate     <= palc_pkg::MS_IDLE;
      failCount  <= '0;
      failFlag   <= 1'b0;
      measResult <= '0;
      measDone   <= 1'b0;
      powerLevel <= '0;
      busRdData  <= '0;
      limitFail  <= 1'b0;
    end else begin
      mstate     <= next_mstate;
      failCount  <= next_failCount;
      failFlag   <= next_failFlag;
      measResult <= next_measResult;
      measDone   <= next_measDone;
      powerLevel <= next_powerLevel;
      busRdData  <= next_busRdData;
      limitFail  <= next_failFlag;
    end
  end

  // checks
  sequence s_clear_req;
    clearNow && !failNow;
  endsequence
  sequence s_record_empty;
    (failCount == '0) && !failFlag;
  endsequence

  a_len_bounds: assert property (@(posedge clk) disable iff (!arst_n)
    (effLen >= palc_pkg::LEN_ONE) && (effLen <= palc_pkg::LEN_MAX))
    else $error("filter length left 1..1024");
  a_bypass_len: assert property (@(posedge clk) disable iff (!arst_n)
    !ctrl.avgOn |-> (effLen == palc_pkg::LEN_ONE))
    else $error("bypass does not use single reading");
  a_len_manual: assert property (@(posedge clk) disable iff (!arst_n)
    wrLen |=> !ctrl.autoLen && (effLen == lenReg || !ctrl.avgOn))
    else $error("length write kept automatic mode");
  a_offset_on: assert property (@(posedge clk) disable iff (!arst_n)
    wrOff |=> offsetOn && (offsetVal == $past(wrSigned)))
    else $error("offset write did not enable offset");
  a_offset_kept: assert property (@(posedge clk) disable iff (!arst_n)
    wrOffOn && !wrOff |=> (offsetVal == $past(offsetVal)) && (offsetOn == $past(busWrData[0])))
    else $error("offset switch disturbed offset value");
  a_limit_range: assert property (@(posedge clk) disable iff (!arst_n)
    (upperLim <= rangeMax || $past(ctrl.unitLin) != ctrl.unitLin) && (lowerLim >= rangeMin || $past(ctrl.unitLin) != ctrl.unitLin))
    else $error("limit outside unit range");
  a_fail_record: assert property (@(posedge clk) disable iff (!arst_n)
    failNow |=> failFlag && (failCount != '0) ##1 limitFail)
    else $error("failure not recorded");
  a_flag_sticky: assert property (@(posedge clk) disable iff (!arst_n)
    failFlag && !clearNow |=> failFlag [*1])
    else $error("failure flag dropped without clear");
  a_count_step: assert property (@(posedge clk) disable iff (!arst_n)
    !clearNow && !failNow |=> $stable(failCount))
    else $error("failure count moved without failure");
  a_clear_zero: assert property (@(posedge clk) disable iff (!arst_n)
    s_clear_req |=> s_record_empty)
    else $error("clear left failures behind");
  a_settled_full: assert property (@(posedge clk) disable iff (!arst_n)
    complete && ctrl.settled |-> (fill == effLen) ##1 measDone)
    else $error("settled result before filter full");
  a_read_once: assert property (@(posedge clk) disable iff (!arst_n)
    !busRd |=> (busRdData == '0))
    else $error("read data outside answer cycle");
  a_keep_record: assert property (@(posedge clk) disable iff (!arst_n)
    wrInit && !ctrl.autoClear |=> failFlag == ($past(failFlag) || $past(failNow)))
    else $error("initiate cleared failures with auto-clear off");
  a_init_clear: assert property (@(posedge clk) disable iff (!arst_n)
    wrInit && ctrl.autoClear && !failNow |=> s_record_empty)
    else $error("auto-clear initiate left failures behind");
  a_result_load: assert property (@(posedge clk) disable iff (!arst_n)
    complete |=> measDone && (measResult == $past(unitVal)))
    else $error("completed result not loaded");
endmodule
`default_nettype wire

// ### bench/palc_host.sv
// host model: register cycles on the plain bus
`timescale 1ns/100ps
`default_nettype none
module palc_host (
  input  wire logic        clk,
  output var  logic [7:0]  busAddr,
  output var  logic [31:0] busWrData,
  output var  logic        busWr,
  output var  logic        busRd,
  input  wire logic [31:0] busRdData
);
  initial begin
    busAddr = 8'h00;
    busWrData = 32'h0;
    busWr = 1'b0;
    busRd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    busAddr <= a;
    busWrData <= v;
    busWr <= 1'b1;
    @(posedge clk);
    busWr <= 1'b0;
    // stale data is inverted so nothing leans on a held value
    busWrData <= ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    busAddr <= a;
    busRd <= 1'b1;
    @(posedge clk);
    busRd <= 1'b0;
    #1;
    d = busRdData;
  endtask
endmodule
`default_nettype wire

// ### bench/test_power_average_limit_checker.sv
// self-checking bench: host cycles, reading source and result model
`timescale 1ns/100ps
`default_nettype none
module test_power_average_limit_checker;
  logic        clk = 1'b0;
  logic        arstN = 1'b0;
  logic [31:0] sampleIn = 32'h0;
  logic [7:0]  busAddr;
  logic [31:0] busWrData;
  logic        busWr;
  logic        busRd;
  logic [31:0] busRdData;
  logic [31:0] measResult;
  logic        measDone;
  logic        limitFail;
  logic [31:0] d;
  int n_mismatch = 0, n_tests = 0;
  int ctrl = 3, len = 1, off = 0, offOn = 0, up = 9000, lo = -9000, cnt = 0, flag = 0, c = 0;
  int per[3] = '{8, 6, 4};
  int tbl[6] = '{500, 1200, 800, 1000, 400, 1201};
  always #20 clk = ~clk;
  palc_host host (.clk(clk), .busAddr(busAddr), .busWrData(busWrData), .busWr(busWr), .busRd(busRd),
    .busRdData(busRdData));
  palc_core #(.NORMAL_CYCLES(8), .DOUBLE_CYCLES(6), .FAST_CYCLES(4), .MAX_LEN(1024)) dut (.clk(clk),
    .arst_n(arstN), .sampleIn(sampleIn), .busAddr(busAddr), .busWrData(busWrData), .busWr(busWr),
    .busRd(busRd), .busRdData(busRdData), .measResult(measResult), .measDone(measDone),
    .limitFail(limitFail));
  task automatic stop_test;
    if (n_mismatch == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  function automatic int clampv(int v, int hi, int lw);
    return v > hi ? hi : (v < lw ? lw : v);
  endfunction
  // model follows every write the way the device should
  task automatic wr(input logic [7:0] a, input int v);
    host.wr(a, v);
    case (a)
      palc_pkg::REG_CTRL: begin
        if (((v ^ ctrl) & 32) != 0) begin
          up = (v & 32) ? 6000 : 9000;
          lo = (v & 32) ? -12000 : -9000;
        end
        ctrl = v;
      end
      palc_pkg::REG_FILTER_LEN: begin
        len = clampv(v, 1024, 1);
        ctrl = ctrl & ~2;
      end
      palc_pkg::REG_OFFSET: begin
        off = v;
        offOn = 1;
      end
      palc_pkg::REG_OFFSET_ON: offOn = v & 1;
      palc_pkg::REG_UPPER: up = clampv(v, (ctrl & 32) ? 20000 : 23000, (ctrl & 32) ? -18000 : -15000);
      palc_pkg::REG_LOWER: lo = clampv(v, (ctrl & 32) ? 20000 : 23000, (ctrl & 32) ? -18000 : -15000);
      palc_pkg::REG_FAIL_CLEAR: begin
        cnt = 0;
        flag = 0;
      end
      palc_pkg::REG_INIT: if ((ctrl & 16) != 0) begin
        cnt = 0;
        flag = 0;
      end
      default: ;
    endcase
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    host.rd(a, d);
    chk(d, e);
  endtask
  task automatic waitd(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (measDone !== 1'b1 && n < 5000);
    if (n >= 5000)
      n_mismatch++;
  endtask
  // hold a level long enough to refill the filter, then one shot
  task automatic meas(input int x);
    int e;
    @(posedge clk) sampleIn <= x;
    repeat (len * 8 + 20) @(posedge clk);
    wr(palc_pkg::REG_INIT, 0);
    waitd(c);
    e = x + (offOn != 0 ? off : 0) - ((ctrl & 32) != 0 ? 3000 : 0);
    chk(measResult, e);
    if ((ctrl & 8) != 0 && (e < lo || e > up)) begin
      cnt++;
      flag = 1;
    end
    @(posedge clk);
    #1;
    chk(measDone, 0);
    @(posedge clk);
    #1;
    chk(limitFail, flag);
    rdc(palc_pkg::REG_FAIL_FLAG, flag);
    rdc(palc_pkg::REG_FAIL_COUNT, cnt);
  endtask
  initial begin
    #4000000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    void'($urandom(37323));
    repeat (20) @(posedge clk);
    arstN <= 1'b1;
    rdc(palc_pkg::REG_CTRL, 3);
    rdc(palc_pkg::REG_UPPER, 9000);
    rdc(palc_pkg::REG_LOWER, -9000);
    rdc(palc_pkg::REG_FAIL_FLAG, 0);
    rdc(8'h40, 0);
    @(posedge clk) sampleIn <= 5000;
    wr(palc_pkg::REG_CTRL, 3 | 256);
    repeat (400) @(posedge clk);
    rdc(palc_pkg::REG_FILTER_LEN, 4);
    wr(palc_pkg::REG_FILTER_LEN, 0);
    rdc(palc_pkg::REG_FILTER_LEN, 1);
    rdc(palc_pkg::REG_CTRL, ctrl);
    wr(palc_pkg::REG_FILTER_LEN, 2000);
    rdc(palc_pkg::REG_FILTER_LEN, 1024);
    wr(palc_pkg::REG_FILTER_LEN, 4);
    wr(palc_pkg::REG_UPPER, 30000);
    rdc(palc_pkg::REG_UPPER, 23000);
    wr(palc_pkg::REG_LOWER, -20000);
    rdc(palc_pkg::REG_LOWER, -15000);
    wr(palc_pkg::REG_CTRL, 33);
    rdc(palc_pkg::REG_LOWER, -12000);
    wr(palc_pkg::REG_UPPER, 30000);
    rdc(palc_pkg::REG_UPPER, up);
    wr(palc_pkg::REG_CTRL, 9);
    wr(palc_pkg::REG_LOWER, 400);
    wr(palc_pkg::REG_UPPER, 1000);
    foreach (tbl[i]) meas(tbl[i]);
    meas(401 + int'($urandom % 599));
    wr(palc_pkg::REG_FAIL_CLEAR, 0);
    rdc(palc_pkg::REG_FAIL_COUNT, 0);
    rdc(palc_pkg::REG_FAIL_FLAG, 0);
    wr(palc_pkg::REG_OFFSET, -300);
    rdc(palc_pkg::REG_OFFSET_ON, 1);
    meas(900);
    meas(650);
    wr(palc_pkg::REG_OFFSET_ON, 0);
    rdc(palc_pkg::REG_OFFSET, -300);
    meas(650);
    wr(palc_pkg::REG_CTRL, 41);
    meas(int'($urandom % 4000));
    wr(palc_pkg::REG_CTRL, 25);
    wr(palc_pkg::REG_UPPER, 1000);
    meas(1500);
    meas(500);
    wr(palc_pkg::REG_CTRL, 0);
    @(posedge clk) sampleIn <= 700;
    wr(palc_pkg::REG_INIT, 0);
    waitd(c);
    chk(measResult, 700);
    // settled restart needs four fresh ticks of eight cycles
    wr(palc_pkg::REG_CTRL, 5);
    wr(palc_pkg::REG_INIT, 0);
    waitd(c);
    chk(c > 24, 1);
    for (int r = 0; r < 3; r++) begin
      wr(palc_pkg::REG_CTRL, 1 | 1024 | (r << 6));
      wr(palc_pkg::REG_INIT, 0);
      waitd(c);
      waitd(c);
      chk(c, per[r]);
    end
    wr(palc_pkg::REG_CTRL, 1);
    stop_test();
  end
endmodule
`default_nettype wire
